// ---- shared/tpc_defines.vh ----
/*
 * Shared constants of the touch panel converter control: command codes,
 * setup data fields, reset values, converter rates and switch selects.
 * Assumes a serial slave in front that decodes the command byte into
 * separate fields and reports address acknowledge and end of transfer.
 */
// Behaviour
// - plate measurements always use the differential reference only
// - references follow driven plate terminals, so results are ratiometric
// - driver-only commands turn drivers on without any conversion
// - resolution bit set gives 8-bit conversions, clear gives 12-bit
// - an 8-bit result fits one data byte, right aligned
// - converter clock divided from system clock: 4MHz 8-bit, 2MHz 12-bit
// - 8-bit conversions make four fewer bit decisions
// - results are unsigned straight binary relative to the reference
// - pen pull-up selectable, 50k after reset, 90k alternative
// - setup data 0001 selects 90k, setup data 0000 restores 50k
// - armed power-down: Y-minus driver on, X-plus joined to pen output
// - armed and touched, X-plus low drives pen interrupt output low
// - measurement cycles disconnect X-plus from the pen detect path
// - driver-only commands disconnect pen detect and force pen output low
// - last command with disable bit set keeps pen detection off
// - address acknowledged for write disables the pen function
// - disable bit zero re-enables pen detection at conversion end
// - filter sorts seven results and averages the middle three
// - filter applies to every input unless setup bypasses it
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

`define TPC_SYS_CLK_HZ 250000000
`define TPC_ADC_HZ_8BIT 4000000
`define TPC_ADC_HZ_12BIT 2000000

`define TPC_CMD_SINGLE_DIODE_TEMPERATURE 4'h0
`define TPC_CMD_AUX 4'h2
`define TPC_CMD_SCALED_DIODE_TEMPERATURE 4'h4
`define TPC_CMD_DRV_X 4'h8
`define TPC_CMD_DRV_Y 4'h9
`define TPC_CMD_DRV_YX 4'ha
`define TPC_CMD_SETUP 4'hb
`define TPC_CMD_MEAS_X 4'hc
`define TPC_CMD_MEAS_Y 4'hd
`define TPC_CMD_MEAS_Z1 4'he
`define TPC_CMD_MEAS_Z2 4'hf

`define TPC_SETUP_PULLUP_BIT 0
`define TPC_SETUP_BYPASS_BIT 1
`define TPC_PULLUP_RESET 1'b0
`define TPC_BYPASS_RESET 1'b0

`define TPC_MSB_BIT 4'hb
`define TPC_LSB_12BIT 4'h0
`define TPC_LSB_8BIT 4'h4
`define TPC_SAMPLE_TICKS 4'h3
`define TPC_FILTER_DEPTH 7

`define TPC_REF_SUPPLY 2'h0
`define TPC_REF_X 2'h1
`define TPC_REF_Y 2'h2

`define TPC_IN_SINGLE_DIODE_TEMPERATURE 3'h0
`define TPC_IN_AUX 3'h1
`define TPC_IN_SCALED_DIODE_TEMPERATURE 3'h2
`define TPC_IN_XP 3'h3
`define TPC_IN_YP 3'h4
`define TPC_IN_YN 3'h5

`endif

// ---- verilog/tpc_clk_div.v ----
/*
 * Converter clock enable: fractional divider from the system clock,
 * giving a one-cycle tick at the fast or slow converter rate.
 * Assumes one system clock; the tick is an enable, not a clock.
 */
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_clk_div #(
    parameter [27:0] CLK_HZ = `TPC_SYS_CLK_HZ,
    parameter [27:0] FAST_HZ = `TPC_ADC_HZ_8BIT,
    parameter [27:0] SLOW_HZ = `TPC_ADC_HZ_12BIT
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire fast,
    output reg tick
);
    reg [27:0] acc;
    wire [27:0] step = fast ? FAST_HZ : SLOW_HZ;
    wire [28:0] sum = {1'b0, acc} + {1'b0, step};

    // accumulator keeps the mean rate exact; 250/4 is not whole
    always @(posedge clk) begin
        if (rst || !run) begin
            acc <= 28'h0;
            tick <= 1'b0;
        end else if (sum >= {1'b0, CLK_HZ}) begin
            acc <= sum[27:0] - CLK_HZ;
            tick <= 1'b1;
        end else begin
            acc <= sum[27:0];
            tick <= 1'b0;
        end
    end
endmodule

// ---- verilog/tpc_mav_filter.v ----
/*
 * Median and average filter: gathers DEPTH results, ranks them and
 * averages the middle three, or passes each result straight on.
 * Assumes results arrive as one-cycle strobes, unsigned, right aligned.
 */
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_mav_filter #(
    parameter W = 12,
    parameter DEPTH = `TPC_FILTER_DEPTH
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire bypass,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg out_valid,
    output reg [W-1:0] out_data
);
    localparam [2:0] MID_LO = (DEPTH[2:0] - 3'h3) >> 1;
    localparam [2:0] MID_HI = MID_LO + 3'h2;
    localparam [2:0] LAST = DEPTH[2:0] - 3'h1;

    reg [W-1:0] store [0:DEPTH-1];
    reg [2:0] count;
    wire [W-1:0] v [0:DEPTH-1];
    reg [2:0] rank;
    reg [W+1:0] sum;
    wire [W+1:0] avg = (sum + 1'b1) / 2'h3;
    integer i;
    integer j;

    // the last value is taken live so the answer lands one cycle later
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : win
            assign v[g] = (g == DEPTH - 1) ? in_data : store[g];
        end
    endgenerate

    // ties ranked by slot so ranks are always a permutation
    always @* begin
        sum = {(W+2){1'b0}};
        rank = 3'h0;
        for (i = 0; i < DEPTH; i = i + 1) begin
            rank = 3'h0;
            for (j = 0; j < DEPTH; j = j + 1) begin
                if (j != i && (v[j] < v[i] || (v[j] == v[i] && j < i))) begin
                    rank = rank + 3'h1;
                end
            end
            if (rank >= MID_LO && rank <= MID_HI) begin
                sum = sum + {2'b00, v[i]};
            end
        end
    end

    always @(posedge clk) begin
        if (rst || clear) begin
            count <= 3'h0;
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
        end else begin
            out_valid <= 1'b0;
            if (in_valid) begin
                if (bypass) begin
                    out_data <= in_data;
                    out_valid <= 1'b1;
                end else if (count == LAST) begin
                    count <= 3'h0;
                    out_data <= avg[W-1:0];
                    out_valid <= 1'b1;
                end else begin
                    store[count] <= in_data;
                    count <= count + 3'h1;
                end
            end
        end
    end
endmodule

// ---- verilog/tpc_control.v ----
/*
 * Touch panel converter control: command execution, panel drivers,
 * ratiometric reference routing, successive approximation sequencing,
 * resolution, filtering and the pen touch interrupt.
 * Assumes a serial slave that strobes the decoded command, the address
 * acknowledge for write and the end of transfer; comparator and X-plus
 * level are synchronous to SYS_CLK.
 */
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_control #(
    parameter [3:0] SAMPLE_TICKS = `TPC_SAMPLE_TICKS,
    parameter FILTER_DEPTH = `TPC_FILTER_DEPTH
) (
    // clock and reset
    input wire SYS_CLK,
    input wire RST,
    // from the serial slave
    input wire ADDR_WRITE_ACK,
    input wire CMD_VALID,
    input wire [3:0] CMD_CODE,
    input wire CMD_TOUCH_DETECT_DISABLE_BIT,
    input wire CMD_MODE_8BIT,
    input wire [3:0] CMD_SETUP_DATA,
    input wire BUS_END,
    // converter core
    input wire ADC_COMP,
    output reg ADC_SAMPLE,
    output reg [11:0] ADC_TRIAL,
    output reg [2:0] ADC_IN_SEL,
    output reg [1:0] REF_POS_SEL,
    output reg [1:0] REF_NEG_SEL,
    // panel drivers
    output reg DRV_XP,
    output reg DRV_XN,
    output reg DRV_YP,
    output reg DRV_YN,
    // pen detect
    input wire XP_LEVEL,
    output reg PEN_XP_CONNECT,
    output reg PEN_PULLUP_90K,
    output reg PEN_TOUCH_INTERRUPT_N,
    // results and status
    output reg [11:0] RESULT,
    output reg RESULT_VALID,
    output reg RESULT_8BIT,
    output reg FILTER_BYPASS,
    output wire BUSY
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_DRIVE = 5'h02;
    localparam [4:0] ST_SAMPLE = 5'h04;
    localparam [4:0] ST_CONVERT = 5'h08;
    localparam [4:0] ST_FILTER = 5'h10;

    // {xp, xn, yp, yn} drivers for a command
    function [3:0] drive_set;
        input [3:0] code;
        begin
            if (code == `TPC_CMD_DRV_X || code == `TPC_CMD_MEAS_X) begin
                drive_set = 4'hc;
            end else if (code == `TPC_CMD_DRV_Y ||
                         code == `TPC_CMD_MEAS_Y) begin
                drive_set = 4'h3;
            end else if (code == `TPC_CMD_DRV_YX ||
                         code == `TPC_CMD_MEAS_Z1 ||
                         code == `TPC_CMD_MEAS_Z2) begin
                drive_set = 4'h6;
            end else begin
                drive_set = 4'h0;
            end
        end
    endfunction

    function is_drive_only;
        input [3:0] code;
        begin
            is_drive_only = (code == `TPC_CMD_DRV_X) ||
                            (code == `TPC_CMD_DRV_Y) ||
                            (code == `TPC_CMD_DRV_YX);
        end
    endfunction

    // {pos, neg} reference select: differential on the driven plate for X, Y; Y positive, X negative for Z1, Z2; supply for other codes
    function [3:0] ref_set;
        input [3:0] code;
        begin
            if (code == `TPC_CMD_MEAS_X) begin
                ref_set = {`TPC_REF_X, `TPC_REF_X};
            end else if (code == `TPC_CMD_MEAS_Y) begin
                ref_set = {`TPC_REF_Y, `TPC_REF_Y};
            end else if (code == `TPC_CMD_MEAS_Z1 ||
                         code == `TPC_CMD_MEAS_Z2) begin
                ref_set = {`TPC_REF_Y, `TPC_REF_X};
            end else begin
                ref_set = {`TPC_REF_SUPPLY, `TPC_REF_SUPPLY};
            end
        end
    endfunction

    function [2:0] in_set;
        input [3:0] code;
        begin
            if (code == `TPC_CMD_MEAS_X) begin
                in_set = `TPC_IN_YP;
            end else if (code == `TPC_CMD_MEAS_Y ||
                         code == `TPC_CMD_MEAS_Z1) begin
                in_set = `TPC_IN_XP;
            end else if (code == `TPC_CMD_MEAS_Z2) begin
                in_set = `TPC_IN_YN;
            end else if (code == `TPC_CMD_AUX) begin
                in_set = `TPC_IN_AUX;
            end else if (code == `TPC_CMD_SCALED_DIODE_TEMPERATURE) begin
                in_set = `TPC_IN_SCALED_DIODE_TEMPERATURE;
            end else begin
                in_set = `TPC_IN_SINGLE_DIODE_TEMPERATURE;
            end
        end
    endfunction

    reg [4:0] state;
    reg [3:0] cmd;
    reg cmd_pd;
    reg cmd_8bit;
    reg [3:0] cmd_setup;
    reg pending;
    reg mode_8bit;
    reg pen_enable;
    reg rearm;
    reg [3:0] tick_count;
    reg [3:0] bit_idx;
    reg [11:0] sar;
    reg [2:0] conv_count;
    reg filt_clear;
    reg filt_in_valid;
    reg [11:0] filt_in_data;
    reg [3:0] next_drv;
    reg [3:0] next_ref;

    wire tick;
    wire filt_valid;
    wire [11:0] filt_data;
    wire converting = (state == ST_SAMPLE) || (state == ST_CONVERT);
    wire start = BUS_END && pending &&
                 (state == ST_IDLE || state == ST_DRIVE);
    wire [11:0] bit_mask = 12'h001 << bit_idx;
    wire [11:0] sar_decided = ADC_COMP ? sar : (sar & ~bit_mask);
    wire [3:0] last_bit = mode_8bit ? `TPC_LSB_8BIT : `TPC_LSB_12BIT;
    wire [2:0] conv_needed = FILTER_BYPASS ? 3'h1 : FILTER_DEPTH[2:0];
    wire pen_armed = (state == ST_IDLE) && pen_enable;

    assign BUSY = (state != ST_IDLE) && (state != ST_DRIVE);

    tpc_clk_div u_div (
        .clk(SYS_CLK),
        .rst(RST),
        .run(converting),
        .fast(mode_8bit),
        .tick(tick)
    );

    tpc_mav_filter #(.W(12), .DEPTH(FILTER_DEPTH)) u_filter (
        .clk(SYS_CLK),
        .rst(RST),
        .clear(filt_clear),
        .bypass(FILTER_BYPASS),
        .in_valid(filt_in_valid),
        .in_data(filt_in_data),
        .out_valid(filt_valid),
        .out_data(filt_data)
    );

    // command capture; a later byte before the end replaces it
    always @(posedge SYS_CLK) begin
        if (RST) begin
            cmd <= 4'h0;
            cmd_pd <= 1'b0;
            cmd_8bit <= 1'b0;
            cmd_setup <= 4'h0;
            pending <= 1'b0;
        end else if (CMD_VALID) begin
            cmd <= CMD_CODE;
            cmd_pd <= CMD_TOUCH_DETECT_DISABLE_BIT;
            cmd_8bit <= CMD_MODE_8BIT;
            cmd_setup <= CMD_SETUP_DATA;
            pending <= 1'b1;
        end else if (start) begin
            pending <= 1'b0;
        end
    end

    // sequencer
    always @(posedge SYS_CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            mode_8bit <= 1'b0;
            pen_enable <= 1'b1;
            rearm <= 1'b0;
            PEN_PULLUP_90K <= `TPC_PULLUP_RESET;
            FILTER_BYPASS <= `TPC_BYPASS_RESET;
            tick_count <= 4'h0;
            bit_idx <= `TPC_MSB_BIT;
            sar <= 12'h000;
            conv_count <= 3'h0;
            filt_clear <= 1'b0;
            filt_in_valid <= 1'b0;
            filt_in_data <= 12'h000;
            RESULT <= 12'h000;
            RESULT_VALID <= 1'b0;
            RESULT_8BIT <= 1'b0;
        end else begin
            filt_clear <= 1'b0;
            filt_in_valid <= 1'b0;
            RESULT_VALID <= 1'b0;
            if (ADDR_WRITE_ACK) begin
                pen_enable <= 1'b0;
            end
            case (state)
                ST_IDLE, ST_DRIVE: begin
                    if (start && cmd == `TPC_CMD_SETUP) begin
                        PEN_PULLUP_90K <=
                            cmd_setup[`TPC_SETUP_PULLUP_BIT];
                        FILTER_BYPASS <=
                            cmd_setup[`TPC_SETUP_BYPASS_BIT];
                        pen_enable <= !cmd_pd;
                        state <= ST_IDLE;
                    end else if (start && is_drive_only(cmd)) begin
                        pen_enable <= 1'b0;
                        state <= ST_DRIVE;
                    end else if (start) begin
                        mode_8bit <= cmd_8bit;
                        rearm <= !cmd_pd;
                        pen_enable <= 1'b0;
                        conv_count <= 3'h0;
                        tick_count <= 4'h0;
                        filt_clear <= 1'b1;
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (tick_count == SAMPLE_TICKS - 4'h1) begin
                            tick_count <= 4'h0;
                            sar <= 12'h800;
                            bit_idx <= `TPC_MSB_BIT;
                            state <= ST_CONVERT;
                        end else begin
                            tick_count <= tick_count + 4'h1;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        if (bit_idx == last_bit) begin
                            sar <= sar_decided;
                            filt_in_valid <= 1'b1;
                            filt_in_data <= mode_8bit ?
                                {4'h0, sar_decided[11:4]} :
                                sar_decided;
                            conv_count <= conv_count + 3'h1;
                            if (conv_count == conv_needed - 3'h1) begin
                                state <= ST_FILTER;
                            end else begin
                                state <= ST_SAMPLE;
                            end
                        end else begin
                            sar <= sar_decided | (bit_mask >> 1);
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ST_FILTER: begin
                    if (filt_valid) begin
                        RESULT <= filt_data;
                        RESULT_8BIT <= mode_8bit;
                        RESULT_VALID <= 1'b1;
                        pen_enable <= rearm;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // switch matrix and pen output, all registered
    always @* begin
        next_drv = 4'h0;
        next_ref = {`TPC_REF_SUPPLY, `TPC_REF_SUPPLY};
        if (pen_armed) begin
            next_drv = 4'h1;
        end else if (state != ST_IDLE) begin
            next_drv = drive_set(cmd);
        end
        if (state != ST_IDLE) begin
            next_ref = ref_set(cmd);
        end
    end

    always @(posedge SYS_CLK) begin
        if (RST) begin
            DRV_XP <= 1'b0;
            DRV_XN <= 1'b0;
            DRV_YP <= 1'b0;
            DRV_YN <= 1'b0;
            REF_POS_SEL <= `TPC_REF_SUPPLY;
            REF_NEG_SEL <= `TPC_REF_SUPPLY;
            ADC_IN_SEL <= `TPC_IN_SINGLE_DIODE_TEMPERATURE;
            ADC_SAMPLE <= 1'b0;
            ADC_TRIAL <= 12'h000;
            PEN_XP_CONNECT <= 1'b0;
            PEN_TOUCH_INTERRUPT_N <= 1'b1;
        end else begin
            {DRV_XP, DRV_XN, DRV_YP, DRV_YN} <= next_drv;
            {REF_POS_SEL, REF_NEG_SEL} <= next_ref;
            ADC_IN_SEL <= in_set(cmd);
            ADC_SAMPLE <= (state == ST_SAMPLE);
            ADC_TRIAL <= sar;
            // leakage through the pull-up would skew a measurement
            PEN_XP_CONNECT <= pen_armed;
            if (state == ST_DRIVE) begin
                PEN_TOUCH_INTERRUPT_N <= 1'b0;
            end else if (pen_armed) begin
                PEN_TOUCH_INTERRUPT_N <= XP_LEVEL;
            end else begin
                PEN_TOUCH_INTERRUPT_N <= 1'b1;
            end
        end
    end
endmodule

// ---- tb/tpc_control_properties.sv ----
/* checker of the converter control ports: setup, pen, drivers, refs.
   assumes bind onto tpc_control; one clock, synchronous reset. */
`timescale 1ns/1ps
`include "tpc_defines.vh"
module tpc_control_properties (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // command side and X-plus level
    input wire logic ADDR_WRITE_ACK,
    input wire logic CMD_VALID,
    input wire logic [3:0] CMD_CODE,
    input wire logic [3:0] CMD_SETUP_DATA,
    input wire logic BUS_END,
    input wire logic XP_LEVEL,
    // converter and panel
    input wire logic ADC_SAMPLE,
    input wire logic [1:0] REF_POS_SEL,
    input wire logic [1:0] REF_NEG_SEL,
    input wire logic DRV_XP,
    input wire logic DRV_XN,
    input wire logic DRV_YP,
    input wire logic DRV_YN,
    // pen and results
    input wire logic PEN_XP_CONNECT,
    input wire logic PEN_PULLUP_90K,
    input wire logic PEN_TOUCH_INTERRUPT_N,
    input wire logic FILTER_BYPASS,
    input wire logic [11:0] RESULT,
    input wire logic RESULT_VALID,
    input wire logic RESULT_8BIT,
    input wire logic BUSY
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire pull_sel = CMD_SETUP_DATA[0];
    sequence setup_start;
        CMD_VALID && CMD_CODE == `TPC_CMD_SETUP ##1 BUS_END && !BUSY;
    endsequence
    sequence drv_start;
        CMD_VALID && CMD_CODE inside {`TPC_CMD_DRV_X, `TPC_CMD_DRV_Y,
            `TPC_CMD_DRV_YX} ##1 BUS_END && !BUSY;
    endsequence
    reset_values_a: assert property ($fell(RST) |->
        !PEN_PULLUP_90K && !FILTER_BYPASS && RESULT == 12'h000)
        else $error("setup state wrong after reset");
    setup_pullup_a: assert property (setup_start |=>
        PEN_PULLUP_90K == $past(pull_sel, 2))
        else $error("pull-up select not taken from setup data");
    drv_force_a: assert property (drv_start |=> ##1
        !PEN_TOUCH_INTERRUPT_N && !PEN_XP_CONNECT && (DRV_XN || DRV_YN))
        else $error("driver-only command left pen path active");
    ack_disable_a: assert property (ADDR_WRITE_ACK &&
        PEN_XP_CONNECT && !BUSY && !BUS_END |-> ##2
        PEN_TOUCH_INTERRUPT_N && !PEN_XP_CONNECT)
        else $error("address acknowledge did not disable pen");
    armed_touch_a: assert property (PEN_XP_CONNECT &&
        !$past(XP_LEVEL) |-> !PEN_TOUCH_INTERRUPT_N)
        else $error("touch while armed not reported");
    armed_drive_a: assert property (PEN_XP_CONNECT |->
        DRV_YN && !DRV_XP && !DRV_YP)
        else $error("armed state drivers wrong");
    meas_detach_a: assert property (BUSY && $past(BUSY)
        |-> !PEN_XP_CONNECT)
        else $error("X-plus joined to pen path during conversion");
    ref_x_a: assert property (ADC_SAMPLE && DRV_XP && DRV_XN |->
        REF_POS_SEL == `TPC_REF_X && REF_NEG_SEL == `TPC_REF_X)
        else $error("reference not on X plate");
    ref_y_a: assert property (ADC_SAMPLE && DRV_YP && DRV_YN |->
        REF_POS_SEL == `TPC_REF_Y && REF_NEG_SEL == `TPC_REF_Y)
        else $error("reference not on Y plate");
    width_8bit_a: assert property (RESULT_VALID && RESULT_8BIT |->
        RESULT[11:8] == 4'h0)
        else $error("8-bit result wider than one byte");
endmodule

// ---- tb/tpc_panel_model.sv ----
/* panel and comparator model: input level with a per-conversion spread,
   touch path to X-plus. assumes sample rises once per conversion. */
`timescale 1ns/1ps
module tpc_panel_model (
    // clock
    input wire logic clk,
    // converter side
    input wire logic sample,
    input wire logic [11:0] trial,
    output logic comp,
    // pen side
    input wire logic xp_connect,
    output logic xp_level,
    // scenario control
    input wire logic touched,
    input wire logic spread,
    input wire logic [11:0] base
);
    logic [2:0] idx = 3'h0;
    logic last_sample = 1'b0;
    logic [11:0] vin;
    always @(posedge clk) begin
        last_sample <= sample;
        if (!spread)
            idx <= 3'h0;
        else if (sample && !last_sample)
            idx <= (idx == 3'h6) ? 3'h0 : idx + 3'h1;
    end
    // spread of seven noisy samples; sorted middle three average to +3
    always @* begin
        case (idx)
            3'h1: vin = base + 12'h009;
            3'h2: vin = base - 12'h032;
            3'h3: vin = base + 12'h003;
            3'h4: vin = base + 12'h03c;
            3'h5: vin = base - 12'h004;
            3'h6: vin = base + 12'h006;
            default: vin = base;
        endcase
        comp = vin >= trial;
        // detached X-plus sits at the pull-up level
        xp_level = !(touched && xp_connect);
    end
endmodule

// ---- tb/tb_touch_adc_pen_irq_control.sv ----
/* bench for the converter control: decoded commands in, panel model on
   the far side. assumes the checker and panel model are compiled. */
`timescale 1ns/1ps
`include "tpc_defines.vh"
module tb_touch_adc_pen_irq_control;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic ack = 1'b0, cmd_valid = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic cmd_dis = 1'b0, cmd_m8 = 1'b0;
    logic [3:0] cmd_data = 4'h0;
    logic bus_end = 1'b0;
    logic touched = 1'b0, spread = 1'b0;
    logic [11:0] base = 12'h000;
    logic comp, xp_level, sample, xp_conn, pull90, irq_n;
    logic res_valid, res_8bit, bypass, xp, xn, yp, yn;
    logic [11:0] trial, result;
    logic [2:0] in_sel;
    wire [11:0] pen = {8'h0, pull90, bypass, xp_conn, irq_n};
    wire [11:0] drv = {5'h0, in_sel, xp, xn, yp, yn};
    int miscompares = 0, checks = 0;
    int cyc;

    always #2 sys_clk = ~sys_clk;

    tpc_control u_tpc_control (
        .SYS_CLK(sys_clk), .RST(rst), .ADDR_WRITE_ACK(ack),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
        .CMD_TOUCH_DETECT_DISABLE_BIT(cmd_dis), .CMD_MODE_8BIT(cmd_m8),
        .CMD_SETUP_DATA(cmd_data), .BUS_END(bus_end), .ADC_COMP(comp),
        .ADC_SAMPLE(sample), .ADC_TRIAL(trial), .ADC_IN_SEL(in_sel),
        .REF_POS_SEL(), .REF_NEG_SEL(), .DRV_XP(xp), .DRV_XN(xn),
        .DRV_YP(yp), .DRV_YN(yn), .XP_LEVEL(xp_level),
        .PEN_XP_CONNECT(xp_conn), .PEN_PULLUP_90K(pull90),
        .PEN_TOUCH_INTERRUPT_N(irq_n), .RESULT(result),
        .RESULT_VALID(res_valid), .RESULT_8BIT(res_8bit),
        .FILTER_BYPASS(bypass), .BUSY()
    );
    tpc_panel_model u_tpc_panel_model (
        .clk(sys_clk), .sample(sample), .trial(trial), .comp(comp),
        .xp_connect(xp_conn), .xp_level(xp_level), .touched(touched),
        .spread(spread), .base(base)
    );

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp, input int tol);
        checks++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("Error at %0t: took %0d cycles", $time, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] code, input logic dis,
            input logic m8, input logic [3:0] data);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_dis <= dis;
        cmd_m8 <= m8;
        cmd_data <= data;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        bus_end <= 1'b1;
        @(posedge sys_clk);
        bus_end <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // bounded so a stuck converter cannot hang the run
    task automatic wait_done;
        cyc = 0;
        while (res_valid !== 1'b1 && cyc < 20000) begin
            @(negedge sys_clk);
            cyc++;
        end
        if (cyc >= 20000) begin
            miscompares++;
            $display("Error at %0t: no result", $time);
        end
    endtask

    task automatic t_reset;
        settle(2);
        chk(pen, 12'h003);
        chk(drv, 12'h001);
        chk(result, 12'h000);
    endtask
    task automatic t_touch;
        @(posedge sys_clk);
        touched <= 1'b1;
        settle(2);
        chk(pen, 12'h002);
        @(posedge sys_clk);
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        settle(2);
        chk(pen, 12'h001);
        cmd(`TPC_CMD_SETUP, 1'b0, 1'b0, 4'h0);
        settle(3);
        chk(pen, 12'h002);
        @(posedge sys_clk);
        touched <= 1'b0;
    endtask
    task automatic t_setup;
        logic [3:0] data [4] = '{4'h1, 4'h0, 4'h2, 4'h0};
        logic [11:0] exp [4] = '{12'h00b, 12'h003, 12'h007, 12'h003};
        for (int i = 0; i < 4; i++) begin
            cmd(`TPC_CMD_SETUP, 1'b0, 1'b0, data[i]);
            settle(1);
            chk(pen, exp[i]);
        end
    endtask
    task automatic t_drivers;
        logic [3:0] code [3] = '{`TPC_CMD_DRV_X, `TPC_CMD_DRV_Y,
            `TPC_CMD_DRV_YX};
        logic [11:0] exp [3] = '{12'h00c, 12'h003, 12'h006};
        for (int i = 0; i < 3; i++) begin
            cmd(code[i], 1'b0, 1'b0, 4'h0);
            settle(2);
            chk(drv, exp[i]);
            chk(pen, 12'h000);
        end
    endtask
    task automatic t_meas;
        cmd(`TPC_CMD_SETUP, 1'b0, 1'b0, 4'h2);
        base <= 12'h5a7;
        cmd(`TPC_CMD_MEAS_X, 1'b0, 1'b1, 4'h0);
        wait_done;
        chk(result, 12'h05a);
        chk({11'h0, res_8bit}, 12'h001);
        chk_near(cyc, 690, 70);
        settle(2);
        chk(pen, 12'h007);
        cmd(`TPC_CMD_MEAS_Y, 1'b0, 1'b0, 4'h0);
        wait_done;
        chk(result, 12'h5a7);
        chk_near(cyc, 1878, 130);
        cmd(`TPC_CMD_MEAS_Y, 1'b1, 1'b0, 4'h0);
        wait_done;
        touched <= 1'b1;
        settle(3);
        chk(pen, 12'h005);
        touched <= 1'b0;
    endtask
    task automatic t_filter;
        logic [3:0] code [2] = '{`TPC_CMD_MEAS_X, `TPC_CMD_AUX};
        cmd(`TPC_CMD_SETUP, 1'b0, 1'b0, 4'h0);
        base <= 12'h800;
        spread <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cmd(code[i], 1'b0, 1'b0, 4'h0);
            wait_done;
            chk(drv, i ? 12'h010 : 12'h04c);
            chk(result, 12'h803);
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_touch;
        t_setup;
        t_drivers;
        t_meas;
        t_filter;
        end_sim;
    end
    // run needs about 31000 cycles
    initial begin
        repeat (50000) @(posedge sys_clk);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule

bind tpc_control tpc_control_properties u_tpc_control_properties (
    .SYS_CLK(SYS_CLK), .RST(RST), .ADDR_WRITE_ACK(ADDR_WRITE_ACK),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
    .CMD_SETUP_DATA(CMD_SETUP_DATA), .BUS_END(BUS_END),
    .XP_LEVEL(XP_LEVEL), .ADC_SAMPLE(ADC_SAMPLE),
    .REF_POS_SEL(REF_POS_SEL), .REF_NEG_SEL(REF_NEG_SEL),
    .DRV_XP(DRV_XP), .DRV_XN(DRV_XN), .DRV_YP(DRV_YP), .DRV_YN(DRV_YN),
    .PEN_XP_CONNECT(PEN_XP_CONNECT), .PEN_PULLUP_90K(PEN_PULLUP_90K),
    .PEN_TOUCH_INTERRUPT_N(PEN_TOUCH_INTERRUPT_N),
    .FILTER_BYPASS(FILTER_BYPASS), .RESULT(RESULT),
    .RESULT_VALID(RESULT_VALID), .RESULT_8BIT(RESULT_8BIT), .BUSY(BUSY)
);
